// ---- verilog/adc_cfg_pkg.sv ----
// package: register layout, reset values and decode types of the converter setup logic
package adc_cfg_pkg;
  // register geometry
  localparam int REG_W = 10;
  localparam int IDX_W = 2;
  localparam int CODE_W = 12;
  // register indices carried on the upper data lines
  localparam logic [1:0] IDX_CONV = 2'h0;
  localparam logic [1:0] IDX_INTF = 2'h1;
  // conversion_setup field positions
  localparam int REFSEL_POS = 0;
  localparam int RSVD_POS = 1;
  localparam int PWRDN_POS = 2;
  localparam int CHLO_POS = 3;
  localparam int CHHI_POS = 4;
  localparam int DIFFLO_POS = 5;
  localparam int DIFFHI_POS = 6;
  localparam int SCAN_POS = 7;
  localparam int TSTLO_POS = 8;
  localparam int TSTHI_POS = 9;
  // interface_setup field positions
  localparam int SWRST_POS = 0;
  localparam int FMT_POS = 7;
  // reset values
  localparam logic [9:0] CONV_RST = 10'h020;
  localparam logic [9:0] INTF_RST = 10'h030;
  // channel field patterns (bits 7..3)
  localparam logic [4:0] CH_SE_POS = 5'h00;
  localparam logic [4:0] CH_SE_NEG = 5'h01;
  localparam logic [4:0] CH_DIFF = 5'h04;
  localparam logic [4:0] CH_SCAN = 5'h11;
  // reference test codes
  localparam logic [11:0] BIN_TOP = 12'hFFF;
  localparam logic [11:0] BIN_MID = 12'h800;
  localparam logic [11:0] BIN_BOT = 12'h000;
  localparam logic [11:0] TWO_TOP = 12'h7FF;
  localparam logic [11:0] TWO_MID = 12'h000;
  localparam logic [11:0] TWO_BOT = 12'h800;
  // selected input route
  typedef enum logic [2:0] {
    ROUTE_POS = 3'b000,
    ROUTE_NEG = 3'b001,
    ROUTE_DIFF = 3'b010,
    ROUTE_SCAN = 3'b011,
    ROUTE_RSVD = 3'b100
  } route_t;
  // one register write from the data bus
  typedef struct packed {
    logic [1:0] idx;
    logic [9:0] val;
  } wr_t;
  // decoded analog control
  typedef struct packed {
    logic ext_ref;
    logic powerdown;
    logic diff_mode;
    logic scan_en;
    logic [1:0] test_sel;
    logic binary_fmt;
  } ctrl_t;
endpackage : adc_cfg_pkg

// ---- verilog/adc_mode_config_regs.sv ----
// file: configuration registers and mode decode of the two-input converter
`timescale 1ns/100ps
module adc_mode_config_regs (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic wr_stb_i,
  input wire logic [11:0] data_i,
  input wire logic conv_tick_i,
  output logic [9:0] conversion_setup_o,
  output logic [9:0] interface_setup_o,
  output adc_cfg_pkg::ctrl_t ctrl_o,
  output adc_cfg_pkg::route_t route_o,
  output logic use_neg_o,
  output logic test_active_o,
  output logic [11:0] test_code_o
);
  import adc_cfg_pkg::*;

  // write strobe and data arrive from pins: two-stage sync
  logic stb_s1_q;
  logic stb_s2_q;
  logic stb_s3_q;
  logic [11:0] dat_s1_q;
  logic [11:0] dat_s2_q;
  logic tick_s1_q;
  logic tick_s2_q;
  logic tick_s3_q;
  wr_t wr;
  logic wr_pulse;
  logic tick_pulse;
  // register contents
  logic [9:0] conv_q;
  logic [9:0] intf_q;
  route_t route_d;
  logic alt_q;

  // decode the channel field into an input route
  function automatic route_t decode_route(input logic [9:0] r);
    logic [4:0] f;
    f = r[SCAN_POS:CHLO_POS];
    case (f)
      CH_SE_POS: decode_route = ROUTE_POS;
      CH_SE_NEG: decode_route = ROUTE_NEG;
      CH_DIFF: decode_route = ROUTE_DIFF;
      CH_SCAN: decode_route = ROUTE_SCAN;
      default: decode_route = ROUTE_RSVD;
    endcase
  endfunction : decode_route

  // synchronisers for the pin inputs
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stb_s1_q <= 1'b0;
      stb_s2_q <= 1'b0;
      stb_s3_q <= 1'b0;
      dat_s1_q <= 12'h000;
      dat_s2_q <= 12'h000;
      tick_s1_q <= 1'b0;
      tick_s2_q <= 1'b0;
      tick_s3_q <= 1'b0;
    end
    else
    begin
      stb_s1_q <= wr_stb_i;
      stb_s2_q <= stb_s1_q;
      stb_s3_q <= stb_s2_q;
      dat_s1_q <= data_i;
      dat_s2_q <= dat_s1_q;
      tick_s1_q <= conv_tick_i;
      tick_s2_q <= tick_s1_q;
      tick_s3_q <= tick_s2_q;
    end
  end

  // split bus word into index and value, act on strobe rising edge
  assign wr = wr_t'(dat_s2_q);
  assign wr_pulse = stb_s2_q & ~stb_s3_q;
  assign tick_pulse = tick_s2_q & ~tick_s3_q;
  assign route_d = decode_route(conv_q);

  // first register; software reset bit forces it to its reset value and the second register to 10'h031
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      conv_q <= CONV_RST;
    end
    else if (intf_q[SWRST_POS])
    begin
      conv_q <= CONV_RST;
    end
    else if (wr_pulse && wr.idx == IDX_CONV)
    begin
      // writes accepted in power-down too
      conv_q <= wr.val;
    end
  end

  // second register; indices 2 and 3 are ignored
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      intf_q <= INTF_RST;
    end
    else if (wr_pulse && wr.idx == IDX_INTF)
    begin
      // reset bit is released only by writing zero or by nrst_i
      intf_q <= wr.val;
    end
    else if (intf_q[SWRST_POS])
    begin
      intf_q <= INTF_RST | 10'h001;
    end
  end

  // autoscan alternation: positive first, then negative, while in scan and not powered down
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      alt_q <= 1'b0;
    end
    else if (route_d != ROUTE_SCAN || conv_q[PWRDN_POS])
    begin
      alt_q <= 1'b0;
    end
    else if (tick_pulse)
    begin
      alt_q <= ~alt_q;
    end
  end

  // registered outputs driven from decoded configuration
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      conversion_setup_o <= CONV_RST;
      interface_setup_o <= INTF_RST;
      ctrl_o <= '0;
      route_o <= ROUTE_POS;
      use_neg_o <= 1'b0;
      test_active_o <= 1'b0;
      test_code_o <= 12'h000;
    end
    else
    begin
      conversion_setup_o <= conv_q;
      interface_setup_o <= intf_q;
      // reserved bit 1 drives nothing
      ctrl_o.ext_ref <= conv_q[REFSEL_POS];
      ctrl_o.powerdown <= conv_q[PWRDN_POS];
      ctrl_o.diff_mode <= conv_q[DIFFLO_POS];
      ctrl_o.scan_en <= conv_q[SCAN_POS];
      ctrl_o.test_sel <= conv_q[TSTHI_POS:TSTLO_POS];
      ctrl_o.binary_fmt <= intf_q[FMT_POS];
      route_o <= route_d;
      case (route_d)
        ROUTE_NEG: use_neg_o <= 1'b1;
        ROUTE_SCAN: use_neg_o <= alt_q;
        default: use_neg_o <= 1'b0;
      endcase
      test_active_o <= |conv_q[TSTHI_POS:TSTLO_POS];
      case (conv_q[TSTHI_POS:TSTLO_POS])
        2'h1: test_code_o <= intf_q[FMT_POS] ? BIN_TOP : TWO_TOP;
        2'h2: test_code_o <= intf_q[FMT_POS] ? BIN_MID : TWO_MID;
        2'h3: test_code_o <= intf_q[FMT_POS] ? BIN_BOT : TWO_BOT;
        default: test_code_o <= 12'h000;
      endcase
    end
  end

  // reset value of the first register
  reset_value_a: assert property (@(posedge clk_i) $rose(nrst_i) |-> conv_q == 10'h020)
    else $error("first register reset value wrong");
  // write reaches register next cycle
  conv_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    wr_pulse && wr.idx == 2'h0 && !intf_q[0] |=> conv_q == $past(wr.val))
    else $error("first register write lost");
  // writes work in power-down
  pd_write_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    conv_q[2] && wr_pulse && wr.idx == 2'h0 && !intf_q[0] |=> conv_q == $past(wr.val))
    else $error("write blocked in power-down");
  // reference select follows bit 0
  ref_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    ##1 ctrl_o.ext_ref == $past(conv_q[0]))
    else $error("reference select mismatch");
  // differential route exactly on pattern
  diff_route_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    conv_q[7:3] == 5'h04 |=> route_o == ROUTE_DIFF)
    else $error("differential route missing");
  // single-ended input follows bit 3
  se_pick_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    conv_q[7:3] == 5'h01 |=> use_neg_o)
    else $error("negative input not picked");
  // autoscan toggles on each tick
  scan_alt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    route_d == ROUTE_SCAN && !conv_q[2] && tick_pulse && $stable(conv_q) |=> alt_q != $past(alt_q))
    else $error("autoscan did not alternate");
  // lower reference test code in straight binary
  low_code_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    conv_q[9:8] == 2'h3 && intf_q[7] |=> test_code_o == 12'h000)
    else $error("lower reference binary code wrong");
endmodule : adc_mode_config_regs

// ---- tb/host_model.sv ----
// host side model: drives the write strobe, data lines and conversion tick
`timescale 1ns/100ps
module host_model (
  input wire logic clk_i,
  output logic stb_o,
  output logic [11:0] data_o,
  output logic tick_o
);
  // idle pins at time zero
  initial
  begin
    stb_o = 1'b0;
    data_o = 12'h000;
    tick_o = 1'b0;
  end
  // one write: index on the top lines, value below, held over the strobe
  task automatic put(input logic [1:0] idx, input logic [9:0] val);
    @(posedge clk_i) #2;
    data_o = {idx, val};
    stb_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #2 stb_o = 1'b0;
    data_o = ~data_o;
    // return off the edge so that callers read settled outputs
    repeat (4) @(posedge clk_i);
    #2;
  endtask : put
  // one conversion tick, wide enough for the synchroniser
  task automatic tick;
    @(posedge clk_i) #2 tick_o = 1'b1;
    repeat (3) @(posedge clk_i);
    #2 tick_o = 1'b0;
    repeat (4) @(posedge clk_i);
    #2;
  endtask : tick
endmodule : host_model

// ---- tb/test_adc_mode_config_regs.sv ----
// self-checking bench of the converter setup registers
`timescale 1ns/100ps
module test_adc_mode_config_regs;
  import adc_cfg_pkg::*;
  // one row: value written, expected route and test code
  typedef struct packed {logic [9:0] v; route_t r; logic [11:0] c;} row_t;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic wr_stb_i;
  logic conv_tick_i;
  logic [11:0] data_i;
  logic [9:0] conversion_setup_o;
  logic [9:0] interface_setup_o;
  ctrl_t ctrl_o;
  route_t route_o;
  logic use_neg_o;
  logic test_active_o;
  logic [11:0] test_code_o;
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  row_t rows [10] = '{'{10'h000, ROUTE_POS, 12'h000}, '{10'h008, ROUTE_NEG, 12'h000},
    '{10'h020, ROUTE_DIFF, 12'h000}, '{10'h088, ROUTE_SCAN, 12'h000}, '{10'h001, ROUTE_POS, 12'h000},
    '{10'h004, ROUTE_POS, 12'h000}, '{10'h120, ROUTE_DIFF, 12'h7FF}, '{10'h220, ROUTE_DIFF, 12'h000},
    '{10'h320, ROUTE_DIFF, 12'h800}, '{10'h010, ROUTE_RSVD, 12'h000}};
  // 25 MHz clock
  always #20 clk_i = ~clk_i;
  host_model host (.clk_i(clk_i), .stb_o(wr_stb_i), .data_o(data_i), .tick_o(conv_tick_i));
  adc_mode_config_regs dut (.clk_i(clk_i), .nrst_i(nrst_i), .wr_stb_i(wr_stb_i), .data_i(data_i),
    .conv_tick_i(conv_tick_i), .conversion_setup_o(conversion_setup_o), .interface_setup_o(interface_setup_o),
    .ctrl_o(ctrl_o), .route_o(route_o), .use_neg_o(use_neg_o), .test_active_o(test_active_o),
    .test_code_o(test_code_o));
  // compare and count
  task automatic cmp(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  // verdict and end of run
  task automatic complete_run;
    if (failures == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  // hang guard
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      complete_run();
    end
  end
  initial
  begin
    repeat (8) @(posedge clk_i);
    #2 nrst_i = 1'b1;
    cmp(conversion_setup_o, 12'h020);
    cmp(interface_setup_o, 12'h030);
    // legal and reserved patterns, twos complement format
    foreach (rows[i])
    begin
      host.put(IDX_CONV, rows[i].v);
      cmp(conversion_setup_o, rows[i].v);
      cmp(12'(route_o), 12'(rows[i].r));
      cmp(12'(ctrl_o), {5'h00, rows[i].v[0], rows[i].v[2], rows[i].v[5], rows[i].v[7], rows[i].v[9:8], 1'b0});
      cmp(test_code_o, rows[i].c);
      cmp(12'(test_active_o), 12'(rows[i].v[9:8] != 2'h0));
    end
    // straight binary codes
    host.put(IDX_INTF, 10'h080);
    cmp(12'(ctrl_o.binary_fmt), 12'h001);
    host.put(IDX_CONV, 10'h120);
    cmp(test_code_o, 12'hFFF);
    host.put(IDX_CONV, 10'h220);
    cmp(test_code_o, 12'h800);
    host.put(IDX_CONV, 10'h320);
    cmp(test_code_o, 12'h000);
    // reserved index leaves both registers alone
    host.put(2'h2, 10'h3FF);
    cmp(conversion_setup_o, 12'h320);
    cmp(interface_setup_o, 12'h080);
    // autoscan alternates, power-down returns to positive
    host.put(IDX_CONV, 10'h088);
    cmp(12'(use_neg_o), 12'h000);
    host.tick();
    cmp(12'(use_neg_o), 12'h001);
    host.tick();
    cmp(12'(use_neg_o), 12'h000);
    host.tick();
    host.put(IDX_CONV, 10'h08C);
    cmp(conversion_setup_o, 12'h08C);
    cmp(12'(use_neg_o), 12'h000);
    // software reset holds both registers
    host.put(IDX_INTF, 10'h001);
    cmp(conversion_setup_o, 12'h020);
    cmp(interface_setup_o, 12'h031);
    host.put(IDX_CONV, 10'h004);
    cmp(conversion_setup_o, 12'h020);
    host.put(IDX_INTF, 10'h000);
    host.put(IDX_CONV, 10'h004);
    cmp(conversion_setup_o, 12'h004);
    // asynchronous reset in mid-run, then a write must land again
    @(posedge clk_i) #2 nrst_i = 1'b0;
    #3 cmp(conversion_setup_o, 12'h020);
    @(posedge clk_i) #2 nrst_i = 1'b1;
    cmp(interface_setup_o, 12'h030);
    host.put(IDX_CONV, 10'h008);
    cmp(conversion_setup_o, 12'h008);
    cmp(12'(use_neg_o), 12'h001);
    complete_run();
  end
endmodule : test_adc_mode_config_regs
